//--- hdl/bsce_core.sv
// Execute logic for the bit test skip-if-set and subroutine call instructions
`timescale 1ns/10ps

module bsce_core (
  input  wire logic        I_CLK_SYS,                 // Instruction clock
  input  wire logic        I_SYS_RST,                 // Sync reset, active high
  input  wire logic        I_INSTR_VALID,             // Word in I_INSTR executes now unless this is a discard slot
  input  wire logic [11:0] I_INSTR,                   // Instruction word
  input  wire logic [10:0] I_PC,                      // Address of that instruction
  input  wire logic [7:0]  I_FILE_DATA,               // Value of addressed file register
  input  wire logic [7:0]  I_STATUS,                  // Status register
  output logic             O_SECOND_CYCLE,            // Discard slot, no-op runs
  output logic             O_SKIP_TAKEN,              // Taken skip marker
  output logic             O_PUSH_VALID,              // Push return address
  output logic [10:0]      O_PUSH_ADDR,               // Return address to stack top
  output logic             O_PC_LOAD,                 // Load new program counter
  output logic [10:0]      O_PC_NEW,                  // New program counter value
  output logic             O_STATUS_WE                // Status write, held low
);

  // Sequencer and output flops
  bsce_pkg::bsce_state_t state_r;                     // Current execute state
  bsce_pkg::bsce_state_t state_nxt;                   // Next execute state
  logic                  second_r;                    // Second cycle flag
  logic                  second_nxt;                  // Next second cycle flag
  logic                  skip_r;                      // Skip marker
  logic                  skip_nxt;                    // Next skip marker
  logic                  push_r;                      // Push strobe
  logic                  push_nxt;                    // Next push strobe
  logic                  load_r;                      // Pc load strobe
  logic                  load_nxt;                    // Next pc load strobe
  logic                  stwe_r;                      // Status write flop
  bsce_pkg::bsce_call_t  call_r;                      // Call addresses
  bsce_pkg::bsce_call_t  call_nxt;                    // Next call addresses

  // Decode
  bsce_pkg::bsce_btf_t   btf;                         // Bit test view of the word
  logic                  is_btskip;                   // Word is bit test skip-if-set
  logic                  is_call;                     // Word is subroutine call
  logic                  bit_val;                     // Tested file bit
  logic                  accept;                      // A word executes this cycle

  assign btf       = bsce_pkg::bsce_btf_t'(I_INSTR);
  // Only the top nibble separates the two forms from each other
  assign is_btskip = (btf.opc == bsce_pkg::OPC_BTSKIP);
  assign is_call   = (I_INSTR[bsce_pkg::OPC_MSB:bsce_pkg::OPC_LSB]
                      == bsce_pkg::OPC_CALL);
  // Words in the discard slot never reach decode
  assign accept    = I_INSTR_VALID && (state_r == bsce_pkg::ST_EXEC);

  // Bit of the addressed register; register file answers combinationally
  bsce_bit_sel u_bit_sel (
    .i_data (I_FILE_DATA),
    .i_idx  (btf.bit_idx),
    .o_bit  (bit_val)
  );

  // Next state and output values
  always_comb begin
    state_nxt  = bsce_pkg::ST_EXEC;
    second_nxt = 1'b0;
    skip_nxt   = 1'b0;
    push_nxt   = 1'b0;
    load_nxt   = 1'b0;
    call_nxt   = call_r;
    unique case (state_r)
      bsce_pkg::ST_EXEC: begin
        if (accept && is_btskip && bit_val) begin
          // Bit set: next slot becomes a no-op
          state_nxt  = bsce_pkg::ST_SKIP;
          second_nxt = 1'b1;
          skip_nxt   = 1'b1;
        end else if (accept && is_call) begin
          // Push and jump both issued at the end of cycle one
          state_nxt  = bsce_pkg::ST_CALL2;
          second_nxt = 1'b1;
          push_nxt   = 1'b1;
          load_nxt   = 1'b1;
          call_nxt.ret_addr = I_PC + 11'h001;
          call_nxt.target   = {I_STATUS[bsce_pkg::STAT_PG_HI],
                               I_STATUS[bsce_pkg::STAT_PG_LO],
                               bsce_pkg::PC_B8_CALL,
                               I_INSTR[bsce_pkg::IMM_MSB:bsce_pkg::IMM_LSB]};
        end
      end
      bsce_pkg::ST_SKIP: begin
        // Prefetched word is thrown away here, whatever it decodes to
        state_nxt = bsce_pkg::ST_EXEC;
      end
      bsce_pkg::ST_CALL2: begin
        // Word fetched from the old address is stale; drop it
        state_nxt = bsce_pkg::ST_EXEC;
      end
      default: begin
        // Illegal code recovers to normal execution
        state_nxt = bsce_pkg::ST_EXEC;
      end
    endcase
  end

  // Registers only; everything computed above
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SYS_RST) begin
      state_r         <= bsce_pkg::ST_EXEC;
      second_r        <= 1'b0;
      skip_r          <= 1'b0;
      push_r          <= 1'b0;
      load_r          <= 1'b0;
      stwe_r          <= 1'b0;
      call_r.ret_addr <= bsce_pkg::PC_RST;
      call_r.target   <= bsce_pkg::PC_RST;
    end else begin
      state_r  <= state_nxt;
      second_r <= second_nxt;
      skip_r   <= skip_nxt;
      push_r   <= push_nxt;
      load_r   <= load_nxt;
      // Neither instruction touches any flag
      stwe_r   <= 1'b0;
      call_r   <= call_nxt;
    end
  end

  // Outputs straight from flops
  assign O_SECOND_CYCLE = second_r;
  assign O_SKIP_TAKEN   = skip_r;
  assign O_PUSH_VALID   = push_r;
  assign O_PUSH_ADDR    = call_r.ret_addr;
  assign O_PC_LOAD      = load_r;
  assign O_PC_NEW       = call_r.target;
  assign O_STATUS_WE    = stwe_r;

  // Helper: previous state, used by checks only
  logic exec_q;                                       // Last cycle was an execute slot
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SYS_RST) begin
      exec_q <= 1'b0;
    end else begin
      exec_q <= (state_r == bsce_pkg::ST_EXEC);
    end
  end

  // Skip is taken when the bit is one
  a_skip_when_set: assert property (
    @(posedge I_CLK_SYS) disable iff (I_SYS_RST)
    (state_r == bsce_pkg::ST_EXEC) && I_INSTR_VALID && (I_INSTR[11:8] == 4'h7)
      && I_FILE_DATA[I_INSTR[7:5]]
    |=> O_SKIP_TAKEN && O_SECOND_CYCLE)
    else $error("Bit set but skip not taken");

  // No skip when the bit is zero
  a_noskip_clear: assert property (
    @(posedge I_CLK_SYS) disable iff (I_SYS_RST)
    (state_r == bsce_pkg::ST_EXEC) && I_INSTR_VALID && (I_INSTR[11:8] == 4'h7)
      && !I_FILE_DATA[I_INSTR[7:5]]
    |=> !O_SECOND_CYCLE && !O_SKIP_TAKEN && !O_PC_LOAD)
    else $error("Bit clear but skip taken");

  // Discarded word causes no action
  a_discard_word: assert property (
    @(posedge I_CLK_SYS) disable iff (I_SYS_RST)
    O_SKIP_TAKEN |=> !O_SECOND_CYCLE && !O_PUSH_VALID && !O_PC_LOAD)
    else $error("Prefetched word was executed after skip");

  // Taken skip lasts exactly two cycles
  a_skip_length: assert property (
    @(posedge I_CLK_SYS) disable iff (I_SYS_RST)
    $rose(O_SKIP_TAKEN) |-> exec_q ##1 !O_SKIP_TAKEN && (state_r == bsce_pkg::ST_EXEC))
    else $error("Skip did not occupy exactly two cycles");

  // Status never written
  a_status_kept: assert property (
    @(posedge I_CLK_SYS) disable iff (I_SYS_RST)
    !O_STATUS_WE)
    else $error("Status flags written");

  // Return address is instruction address plus one
  a_push_addr: assert property (
    @(posedge I_CLK_SYS) disable iff (I_SYS_RST)
    (state_r == bsce_pkg::ST_EXEC) && I_INSTR_VALID && (I_INSTR[11:8] == 4'h9)
    |=> O_PUSH_VALID && (O_PUSH_ADDR == 11'($past(I_PC) + 11'h001)))
    else $error("Wrong return address pushed");

  // Low pc bits come from the immediate
  a_pc_low: assert property (
    @(posedge I_CLK_SYS) disable iff (I_SYS_RST)
    (state_r == bsce_pkg::ST_EXEC) && I_INSTR_VALID && (I_INSTR[11:8] == 4'h9)
    |=> O_PC_LOAD && (O_PC_NEW[7:0] == $past(I_INSTR[7:0])))
    else $error("Immediate not loaded into low pc bits");

  // Page bits come from status 6:5
  a_pc_page: assert property (
    @(posedge I_CLK_SYS) disable iff (I_SYS_RST)
    (state_r == bsce_pkg::ST_EXEC) && I_INSTR_VALID && (I_INSTR[11:8] == 4'h9)
    |=> (O_PC_NEW[10] == $past(I_STATUS[6])) && (O_PC_NEW[9] == $past(I_STATUS[5])))
    else $error("Page bits not copied from status");

  // Bit 8 cleared and call spans two cycles
  a_call_shape: assert property (
    @(posedge I_CLK_SYS) disable iff (I_SYS_RST)
    O_PC_LOAD |-> !O_PC_NEW[8] && O_SECOND_CYCLE && O_PUSH_VALID
      ##1 !O_PC_LOAD && !O_SECOND_CYCLE)
    else $error("Call shape wrong");

  // Second cycle only follows a bit test or call opcode
  a_decode_only: assert property (
    @(posedge I_CLK_SYS) disable iff (I_SYS_RST)
    O_SECOND_CYCLE |-> $past(I_INSTR_VALID) && exec_q
      && (($past(I_INSTR[11:8]) == 4'h9) || ($past(I_INSTR[11:8]) == 4'h7)))
    else $error("Second cycle without a decoded instruction");

endmodule

//--- hdl/bsce_pkg.sv
// Shared constants and carrier types for the bit-skip and call execute block
package bsce_pkg;

  // Widths of the datapath
  localparam int unsigned INSTR_W     = 12;           // Instruction word width
  localparam int unsigned PC_W        = 11;           // Program counter width
  localparam int unsigned DATA_W      = 8;            // File register width

  // Opcode field position and values
  localparam int unsigned OPC_MSB     = 11;           // Top bit of major opcode
  localparam int unsigned OPC_LSB     = 8;            // Bottom bit of major opcode
  localparam logic [3:0]  OPC_BTSKIP  = 4'h7;         // Bit test, skip if set
  localparam logic [3:0]  OPC_CALL    = 4'h9;         // Subroutine call

  // Field positions of the bit test form
  localparam int unsigned BIT_MSB     = 7;            // Bit index field top
  localparam int unsigned BIT_LSB     = 5;            // Bit index field bottom
  localparam int unsigned FADR_MSB    = 4;            // File address field top
  localparam int unsigned FADR_LSB    = 0;            // File address field bottom

  // Field positions of the call form and page source
  localparam int unsigned IMM_MSB     = 7;            // Immediate top bit
  localparam int unsigned IMM_LSB     = 0;            // Immediate bottom bit
  localparam int unsigned STAT_PG_HI  = 6;            // Status page bit to pc bit 10
  localparam int unsigned STAT_PG_LO  = 5;            // Status page bit to pc bit 9
  localparam logic        PC_B8_CALL  = 1'b0;         // Pc bit 8 forced on call

  // Cycle counts of the two instructions
  localparam int unsigned CYC_SKIP    = 2;            // Bit test with skip taken
  localparam int unsigned CYC_NOSKIP  = 1;            // Bit test, no skip
  localparam int unsigned CYC_CALL    = 2;            // Call, always

  // Reset values
  localparam logic [PC_W-1:0] PC_RST  = 11'h000;      // Address outputs at reset

  // Execute sequencer states
  typedef enum logic [1:0] {
    ST_EXEC    = 2'b00,                               // Normal one-cycle execute
    ST_SKIP    = 2'b01,                               // No-op slot after taken skip
    ST_CALL2   = 2'b10                                // Second cycle of a call
  } bsce_state_t;

  // Call result travelling to stack and fetch path
  typedef struct packed {
    logic [PC_W-1:0] ret_addr;                        // Pushed return address
    logic [PC_W-1:0] target;                          // New program counter
  } bsce_call_t;

  // Decoded bit test operands
  typedef struct packed {
    logic [3:0] opc;                                  // Major opcode
    logic [2:0] bit_idx;                              // Selected bit
    logic [4:0] faddr;                                // File register address
  } bsce_btf_t;

endpackage

//--- hdl/bsce_bit_sel.sv
// Bit selector picking one bit of a file register byte
`timescale 1ns/10ps

module bsce_bit_sel (
  input  wire logic [7:0] i_data,                     // File register value
  input  wire logic [2:0] i_idx,                      // Bit index 0..7
  output logic            o_bit                       // Selected bit
);

  // Indexed select keeps a single mux, no decode tree
  always_comb begin
    o_bit = i_data[i_idx];
  end

endmodule

//--- dv/bsce_ret_stack_model.sv
// Far side model: return stack top and fetch path program counter
`timescale 1ns/10ps

module bsce_ret_stack_model (
  input  wire logic        i_clk,       // Instruction clock
  input  wire logic        i_rst,       // Sync reset, active high
  input  wire logic        i_push,      // Push strobe
  input  wire logic [10:0] i_push_addr, // Return address pushed
  input  wire logic        i_pc_load,   // Fetch path load strobe
  input  wire logic [10:0] i_pc_new,    // New program counter
  output logic      [10:0] o_top,       // Top of return stack
  output logic      [10:0] o_pc         // Fetch path program counter
);
  // One level is enough here; depth belongs to the real stack, not this block
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_top <= 11'h000;
      o_pc  <= 11'h000;
    end else begin
      if (i_push) o_top <= i_push_addr;
      if (i_pc_load) o_pc <= i_pc_new;
    end
  end
endmodule

//--- dv/test_bit_skip_and_call_execute.sv
// Directed bench for the bit test skip and call execute block
`timescale 1ns/10ps

module test_bit_skip_and_call_execute;
  logic        clk, rst, valid;          // Clock, reset, word valid
  logic [11:0] instr;                    // Instruction word
  logic [10:0] pc;                       // Its address
  logic [7:0]  fdata, status;            // File value, status
  logic        sec, skp, pv, pl, swe;    // Strobes seen
  logic [10:0] paddr, pnew, top, fpc;    // Addresses seen
  int          err_count, samples_checked;

  bsce_core dut (.I_CLK_SYS(clk), .I_SYS_RST(rst), .I_INSTR_VALID(valid), .I_INSTR(instr),
    .I_PC(pc), .I_FILE_DATA(fdata), .I_STATUS(status), .O_SECOND_CYCLE(sec),
    .O_SKIP_TAKEN(skp), .O_PUSH_VALID(pv), .O_PUSH_ADDR(paddr), .O_PC_LOAD(pl),
    .O_PC_NEW(pnew), .O_STATUS_WE(swe));
  bsce_ret_stack_model far (.i_clk(clk), .i_rst(rst), .i_push(pv), .i_push_addr(paddr),
    .i_pc_load(pl), .i_pc_new(pnew), .o_top(top), .o_pc(fpc));

  // 125 MHz instruction clock
  always #4 clk = ~clk;

  // Compare any value up to address width
  task automatic chk(input string what, input logic [10:0] exp, input logic [10:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // Strobes as {second, skip, push, load}; status write must stay low
  task automatic flags(input logic [3:0] e);
    chk("strobes", {7'h00, e}, {7'h00, sec, skp, pv, pl});
    chk("status write", 11'h000, {10'h000, swe});
  endtask

  // Inputs change at the falling edge, outputs of the last rise are settled then
  task automatic drv(input logic v, input logic [11:0] w, input logic [10:0] p,
                     input logic [7:0] fd, input logic [7:0] st);
    @(negedge clk);
    valid = v; instr = w; pc = p; fdata = fd; status = st;
  endtask

  // Set bit at every index skips; a call in the slot must be dropped
  task automatic test_skip();
    for (int b = 0; b < 8; b++) begin
      drv(1'b1, {4'h7, b[2:0], 5'h0a}, 11'h010, 8'h01 << b, 8'hff);
      drv(1'b1, 12'h9aa, 11'h011, 8'hff, 8'hff);
      flags(4'hc);
      drv(1'b0, 12'h000, 11'h012, 8'h00, 8'h00);
      flags(4'h0);
      chk("dropped push addr", 11'h000, paddr);
    end
    $display("skip test done");
  endtask

  // Clear bit never skips; the very next call is taken back to back
  task automatic test_noskip();
    for (int b = 0; b < 8; b++) begin
      drv(1'b1, {4'h7, b[2:0], 5'h03}, 11'h120, ~(8'h01 << b), 8'hff);
      drv(1'b1, 12'h955, 11'h123, 8'hff, 8'h20);
      flags(4'h0);
      drv(1'b0, 12'h000, 11'h124, 8'h00, 8'h00);
      flags(4'hb);
      chk("push addr", 11'h124, paddr);
    end
    $display("no skip test done");
  endtask

  // Calls at boundary addresses, immediates and page bits
  task automatic test_call();
    logic [10:0] pcs [4] = '{11'h7ff, 11'h000, 11'h1ff, 11'h2a5};
    logic [7:0]  ks  [4] = '{8'hff, 8'h00, 8'h5a, 8'ha5};
    logic [7:0]  sts [4] = '{8'h60, 8'h9f, 8'h40, 8'h20};
    logic [10:0] tgt;
    for (int i = 0; i < 4; i++) begin
      tgt = {sts[i][6], sts[i][5], 1'b0, ks[i]};
      drv(1'b1, {4'h9, ks[i]}, pcs[i], 8'h00, sts[i]);
      drv(1'b1, 12'h7e0, 11'h055, 8'hff, 8'hff);
      flags(4'hb);
      chk("push addr", pcs[i] + 11'h001, paddr);
      chk("new pc", tgt, pnew);
      drv(1'b0, 12'h000, 11'h000, 8'h00, 8'h00);
      flags(4'h0);
      chk("stack top", pcs[i] + 11'h001, top);
      chk("fetch pc", tgt, fpc);
    end
    $display("call test done");
  endtask

  // Every other opcode, all bits set, gives no action at all
  task automatic test_other();
    for (int op = 0; op < 16; op++) begin
      if (op != 7 && op != 9) begin
        drv(1'b1, {op[3:0], 8'hff}, 11'h3c0, 8'hff, 8'hff);
        drv(1'b0, 12'h000, 11'h3c1, 8'h00, 8'h00);
        flags(4'h0);
      end
    end
    $display("other opcode test done");
  endtask

  // Single place where the run ends
  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Guard against a hang; fixed latencies make this a loose bound
  initial begin
    #200000;
    err_count++;
    report_and_stop();
  end

  // Main sequence: reset eight cycles, then each scenario
  initial begin
    clk = 1'b0; rst = 1'b1; valid = 1'b0; instr = 12'h000;
    pc = 11'h000; fdata = 8'h00; status = 8'h00;
    err_count = 0; samples_checked = 0;
    repeat (8) @(negedge clk);
    rst = 1'b0;
    flags(4'h0);
    chk("reset push addr", 11'h000, paddr);
    test_skip();
    test_noskip();
    test_call();
    test_other();
    report_and_stop();
  end
endmodule
